// file: design/adsc_consts.vh
// Register map, field positions, reset values and codes of the converter status and scan control
`ifndef ADSC_CONSTS_VH
`define ADSC_CONSTS_VH

// Register byte offsets, decoded on haddr[3:0]
`define ADSC_ADDR_W          4
`define ADSC_STATUS_OFF      4'h0
`define ADSC_CTRL1_OFF       4'h4

// Status register fields
`define ADSC_STATUS_W        5
`define ADSC_ST_WDOG         0
`define ADSC_ST_REG_DONE     1
`define ADSC_ST_INJ_DONE     2
`define ADSC_ST_INJ_START    3
`define ADSC_ST_REG_START    4
`define ADSC_STATUS_RST      5'h00
`define ADSC_STATUS_ALL      5'h1F

// First control register fields
`define ADSC_CTRL1_W         16
`define ADSC_CT_CHSEL_MSB    4
`define ADSC_CT_CHSEL_LSB    0
`define ADSC_CT_REG_IE       5
`define ADSC_CT_WDOG_IE      6
`define ADSC_CT_INJ_IE       7
`define ADSC_CT_SCAN         8
`define ADSC_CT_WDOG_SGL     9
`define ADSC_CT_AUTO_INJ     10
`define ADSC_CT_REG_STEP     11
`define ADSC_CT_INJ_STEP     12
`define ADSC_CT_STEP_MSB     15
`define ADSC_CT_STEP_LSB     13
`define ADSC_CTRL1_RST       16'h0000

// Channel numbering
`define ADSC_CH_MAX          5'h11
`define ADSC_CH_GND_A        5'h09
`define ADSC_CH_GND_B        5'h0E

// Sample width
`define ADSC_DATA_W          12

`endif

// file: design/adsc_scan_ctrl.v
// Converter status flags, first control register and regular/injected scan sequencer on AHB-Lite
//
// Function
// - Watchdog event sets status bit 0; stays until software writes zero.
// - Regular conversion completion sets status bit 1; zero until a completion.
// - Injected group completion sets status bit 2; software clears by writing zero.
// - Injected group start sets status bit 3; zero if none started.
// - Regular group start sets status bit 4; bits 31:5 reserved, read zero.
// - Control bits 4:0 select watchdog channel 0..17; higher codes reserved.
// - Third converter instance grounds channels 9 and 14..17; results read zero.
// - Control bit 5 enables interrupt on regular conversion completion.
// - Control bit 6 with scan: watchdog hit raises interrupt and aborts scan.
// - Control bit 7 enables interrupt on injected group completion.
// - Control bit 8 scans every listed sequence channel in order.
// - In scan, completion flags set only after the last sequence channel.
// - Control bit 9 zero guards all channels; one guards selected channel only.
// - Control bit 10 starts injected group automatically after regular completion.
// - Control bit 11 enables discontinuous regular group conversion.
// - Control bit 12 enables discontinuous injected group conversion.
// - Watchdog event when a result lies outside the high/low threshold window.
// - Bits 15:13 give channels per discontinuous step, 000 one, 111 eight.
//
// Design decision made here: the AHB-Lite register port.
`include "adsc_consts.vh"

module adsc_scan_ctrl #(
  parameter INSTANCE_THREE = 0
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        regular_trigger,
  input  wire        injected_trigger,
  input  wire [3:0]  regular_last_pos,
  input  wire [1:0]  injected_last_pos,
  input  wire        watchdog_enable,
  input  wire [11:0] watchdog_high,
  input  wire [11:0] watchdog_low,
  output reg         conv_start,
  output reg         conv_injected,
  output reg  [3:0]  conv_position,
  input  wire        conv_done,
  input  wire [4:0]  conv_channel,
  input  wire [11:0] conv_data,
  output reg         result_valid,
  output reg         result_injected,
  output reg  [11:0] result_data,
  output reg         irq
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_REG  = 2'b01;
  localparam [1:0] ST_INJ  = 2'b10;

  // Channels wired to ground on the third instance
  function is_grounded;
    input [4:0] ch;
    begin
      is_grounded = (INSTANCE_THREE != 0) &&
                    ((ch == `ADSC_CH_GND_A) || ((ch >= `ADSC_CH_GND_B) && (ch <= `ADSC_CH_MAX)));
    end
  endfunction

  // Register decode on the low address bits, shared by write and read paths
  function sel_status;
    input [`ADSC_ADDR_W-1:0] a;
    begin
      sel_status = (a == `ADSC_STATUS_OFF);
    end
  endfunction

  function sel_ctrl1;
    input [`ADSC_ADDR_W-1:0] a;
    begin
      sel_ctrl1 = (a == `ADSC_CTRL1_OFF);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: address phase capture, zero wait states

  reg                    wr_pend;
  reg [`ADSC_ADDR_W-1:0] wr_addr;
  reg [`ADSC_STATUS_W-1:0] status;
  reg [`ADSC_CTRL1_W-1:0]  ctrl1;

  wire addr_valid = hsel && hready && htrans[1];
  wire wr_status  = wr_pend && sel_status(wr_addr);
  wire wr_ctrl1   = wr_pend && sel_ctrl1(wr_addr);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= {`ADSC_ADDR_W{1'b0}};
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= addr_valid && hwrite;
      wr_addr   <= haddr[`ADSC_ADDR_W-1:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control field decode

  wire [4:0] wd_chsel   = ctrl1[`ADSC_CT_CHSEL_MSB:`ADSC_CT_CHSEL_LSB];
  wire       reg_ie     = ctrl1[`ADSC_CT_REG_IE];
  wire       wd_ie      = ctrl1[`ADSC_CT_WDOG_IE];
  wire       inj_ie     = ctrl1[`ADSC_CT_INJ_IE];
  wire       scan_en    = ctrl1[`ADSC_CT_SCAN];
  wire       wd_single  = ctrl1[`ADSC_CT_WDOG_SGL];
  wire       auto_inj   = ctrl1[`ADSC_CT_AUTO_INJ];
  wire       reg_step   = ctrl1[`ADSC_CT_REG_STEP];
  wire       inj_step   = ctrl1[`ADSC_CT_INJ_STEP];
  wire [2:0] step_count = ctrl1[`ADSC_CT_STEP_MSB:`ADSC_CT_STEP_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog compare on each finished conversion

  wire [11:0] sample   = is_grounded(conv_channel) ? 12'h000 : conv_data;
  wire        wd_chan  = !wd_single || ((wd_chsel <= `ADSC_CH_MAX) && (conv_channel == wd_chsel));
  wire        wd_above = (sample > watchdog_high);
  wire        wd_below = (sample < watchdog_low);
  wire        wd_out   = wd_above || wd_below;
  wire        wd_hit   = conv_done && watchdog_enable && wd_chan && wd_out;
  // Abort drops the rest of the sequence and withholds the done flag
  wire        abort    = wd_hit && wd_ie && scan_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // One conv_start per conversion; the core answers each with one conv_done.
  // Positions advance on conv_done, so a lost done stalls the group until reset.
  // Step counter is shared by both groups and cleared whenever a group ends.
  reg [1:0] state;
  reg [3:0] reg_pos;
  reg [1:0] inj_pos;
  reg [2:0] step_cnt;
  reg       inj_pend;

  reg [1:0] next_state;
  reg [3:0] next_reg_pos;
  reg [1:0] next_inj_pos;
  reg [2:0] next_step_cnt;
  reg       next_inj_pend;
  reg       next_start;
  reg       next_injected;
  reg [3:0] next_position;
  reg [`ADSC_STATUS_W-1:0] seq_set;

  wire reg_last = !scan_en || (reg_pos == regular_last_pos);
  wire inj_last = !scan_en || (inj_pos == injected_last_pos);
  wire step_end = (step_cnt == step_count);

  always @* begin
    next_state    = state;
    next_reg_pos  = reg_pos;
    next_inj_pos  = inj_pos;
    next_step_cnt = step_cnt;
    next_inj_pend = inj_pend || (injected_trigger && (state != ST_IDLE));
    next_start    = 1'b0;
    next_injected = conv_injected;
    next_position = conv_position;
    seq_set       = {`ADSC_STATUS_W{1'b0}};
    seq_set[`ADSC_ST_WDOG] = wd_hit;
    case (state)
      ST_IDLE: begin
        if (injected_trigger || inj_pend) begin
          next_state    = ST_INJ;
          next_inj_pend = 1'b0;
          next_start    = 1'b1;
          next_injected = 1'b1;
          next_position = {2'b00, inj_pos};
          seq_set[`ADSC_ST_INJ_START] = 1'b1;
        end else if (regular_trigger) begin
          next_state    = ST_REG;
          next_start    = 1'b1;
          next_injected = 1'b0;
          next_position = reg_pos;
          seq_set[`ADSC_ST_REG_START] = 1'b1;
        end
      end
      ST_REG: begin
        if (conv_done) begin
          if (reg_last || abort) begin
            next_reg_pos  = 4'h0;
            next_step_cnt = 3'b000;
            seq_set[`ADSC_ST_REG_DONE] = !abort;
            if (!abort && (auto_inj || inj_pend)) begin
              next_state    = ST_INJ;
              next_inj_pend = 1'b0;
              next_start    = 1'b1;
              next_injected = 1'b1;
              next_position = {2'b00, inj_pos};
              seq_set[`ADSC_ST_INJ_START] = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end else begin
            next_reg_pos = reg_pos + 4'h1;
            if (reg_step && step_end) begin
              next_step_cnt = 3'b000;
              next_state    = ST_IDLE;
            end else begin
              next_step_cnt = reg_step ? step_cnt + 3'b001 : 3'b000;
              next_start    = 1'b1;
              next_position = reg_pos + 4'h1;
            end
          end
        end
      end
      ST_INJ: begin
        if (conv_done) begin
          if (inj_last || abort) begin
            next_inj_pos  = 2'b00;
            next_step_cnt = 3'b000;
            next_state    = ST_IDLE;
            seq_set[`ADSC_ST_INJ_DONE] = !abort;
          end else begin
            next_inj_pos = inj_pos + 2'b01;
            if (inj_step && step_end) begin
              next_step_cnt = 3'b000;
              next_state    = ST_IDLE;
            end else begin
              next_step_cnt = inj_step ? step_cnt + 3'b001 : 3'b000;
              next_start    = 1'b1;
              next_position = {2'b00, inj_pos + 2'b01};
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= ST_IDLE;
      reg_pos       <= 4'h0;
      inj_pos       <= 2'b00;
      step_cnt      <= 3'b000;
      inj_pend      <= 1'b0;
      conv_start    <= 1'b0;
      conv_injected <= 1'b0;
      conv_position <= 4'h0;
    end else begin
      state         <= next_state;
      reg_pos       <= next_reg_pos;
      inj_pos       <= next_inj_pos;
      step_cnt      <= next_step_cnt;
      inj_pend      <= next_inj_pend;
      conv_start    <= next_start;
      conv_injected <= next_injected;
      conv_position <= next_position;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result capture

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_valid    <= 1'b0;
      result_injected <= 1'b0;
      result_data     <= 12'h000;
    end else begin
      result_valid <= conv_done && (state != ST_IDLE);
      if (conv_done) begin
        result_injected <= (state == ST_INJ);
        result_data     <= sample;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers: flags clear on written zero, hardware set wins

  wire [`ADSC_STATUS_W-1:0] next_status;
  wire [`ADSC_CTRL1_W-1:0]  next_ctrl1  = wr_ctrl1 ? hwdata[`ADSC_CTRL1_W-1:0] : ctrl1;
  wire [`ADSC_ADDR_W-1:0]   rd_addr     = haddr[`ADSC_ADDR_W-1:0];
  wire                      rd_req      = addr_valid && !hwrite;
  wire                      rd_status   = rd_req && sel_status(rd_addr);
  wire                      rd_ctrl1    = rd_req && sel_ctrl1(rd_addr);
  reg  [31:0]               next_rdata;

  genvar gi;
  generate
    for (gi = 0; gi < `ADSC_STATUS_W; gi = gi + 1) begin : g_flag
      // Written zero clears, hardware set in the same cycle wins
      assign next_status[gi] = (status[gi] && !(wr_status && !hwdata[gi])) || seq_set[gi];
    end
  endgenerate

  // Read value forwarded from next state so a write just before is seen
  always @* begin
    next_rdata = 32'h00000000;
    if (rd_status) begin
      next_rdata = {27'h0000000, next_status};
    end else if (rd_ctrl1) begin
      next_rdata = {16'h0000, next_ctrl1};
    end
  end

  // Interrupt sources, each gated by its own enable
  wire irq_wdog = next_status[`ADSC_ST_WDOG]     && wd_ie;
  wire irq_reg  = next_status[`ADSC_ST_REG_DONE] && reg_ie;
  wire irq_inj  = next_status[`ADSC_ST_INJ_DONE] && inj_ie;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= `ADSC_STATUS_RST;
      ctrl1  <= `ADSC_CTRL1_RST;
      hrdata <= 32'h00000000;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      ctrl1  <= next_ctrl1;
      hrdata <= next_rdata;
      irq    <= irq_wdog || irq_reg || irq_inj;
    end
  end

endmodule

// file: verif/adsc_scan_ctrl_sva.sv
// Checker of bus and converter-link timing for the scan control block
module adsc_chk #(
  parameter INSTANCE_THREE = 0
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        regular_trigger,
  input wire        injected_trigger,
  input wire        conv_start,
  input wire        conv_injected,
  input wire        conv_done,
  input wire [4:0]  conv_channel,
  input wire [11:0] conv_data,
  input wire        result_valid,
  input wire        result_injected,
  input wire [11:0] result_data,
  input wire        irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       rd_ph;
  logic       wr_ph;
  logic       gnd_q;
  logic [3:0] a_q;
  ////////////////////////////////////////////////////////////
  // Data-phase tracking and grounded-channel marker
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph <= 1'b0;
      wr_ph <= 1'b0;
      gnd_q <= 1'b0;
      a_q   <= 4'h0;
    end else begin
      rd_ph <= hsel & hready & htrans[1] & !hwrite;
      wr_ph <= hsel & hready & htrans[1] & hwrite;
      a_q   <= haddr[3:0];
      gnd_q <= (INSTANCE_THREE != 0) && (conv_channel == 5'h09 || (conv_channel >= 5'h0E && conv_channel <= 5'h11));
    end
  end
  ////////////////////////////////////////////////////////////
  property p_resp_ok; hreadyout && !hresp; endproperty
  a_resp_ok: assert property (p_resp_ok) else $error("bus not ready or error");
  property p_st_rsv; rd_ph && a_q == 4'h0 |-> hrdata[31:5] == 27'h0; endproperty
  a_st_rsv: assert property (p_st_rsv) else $error("status reserved bits set");
  property p_ct_rsv; rd_ph && a_q == 4'h4 |-> hrdata[31:16] == 16'h0; endproperty
  a_ct_rsv: assert property (p_ct_rsv) else $error("control upper bits set");
  property p_rd_idle; !rd_ph |-> hrdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_cause; conv_start |-> $past(regular_trigger) || $past(injected_trigger) || $past(conv_done); endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without cause");
  property p_res_data; result_valid && !gnd_q |-> $past(conv_done) && result_data == $past(conv_data); endproperty
  a_res_data: assert property (p_res_data) else $error("result data mismatch");
  property p_res_gnd; result_valid && gnd_q |-> result_data == 12'h000; endproperty
  a_res_gnd: assert property (p_res_gnd) else $error("grounded channel not zero");
  property p_irq_rise; $rose(irq) |-> result_valid || $past(wr_ph) || $past(wr_ph, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
  property p_res_grp; result_valid |-> result_injected == $past(conv_injected); endproperty
  a_res_grp: assert property (p_res_grp) else $error("result group mismatch");
  c_result: cover property (result_valid);
  c_irq: cover property ($rose(irq));
  c_ground: cover property (result_valid && gnd_q);
endmodule

// file: verif/tb_adsc_scan_ctrl.sv
// Testbench of the converter status and scan control block
module tb_adsc_scan_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, conv_done = 1'h0;
  logic        regular_trigger = 1'h0, injected_trigger = 1'h0, watchdog_enable = 1'h0;
  logic [1:0]  htrans = 2'h0, injected_last_pos = 2'h0, sh = 2'h0;
  logic [3:0]  regular_last_pos = 4'h0;
  logic [4:0]  conv_channel = 5'h03;
  logic [11:0] watchdog_high = 12'hFFF, watchdog_low = 12'h000, conv_data = 12'h5A5, last;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  wire         hreadyout, hresp, conv_start, conv_injected, result_valid, result_injected, irq;
  wire  [3:0]  conv_position;
  wire  [11:0] result_data;
  wire  [31:0] hrdata;
  int          error_cnt = 0, check_count = 0, cyc = 0, nres = 0;
  adsc_scan_ctrl #(.INSTANCE_THREE(1)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .regular_trigger(regular_trigger), .injected_trigger(injected_trigger),
    .regular_last_pos(regular_last_pos), .injected_last_pos(injected_last_pos), .watchdog_enable(watchdog_enable),
    .watchdog_high(watchdog_high), .watchdog_low(watchdog_low), .conv_start(conv_start),
    .conv_injected(conv_injected), .conv_position(conv_position), .conv_done(conv_done),
    .conv_channel(conv_channel), .conv_data(conv_data), .result_valid(result_valid),
    .result_injected(result_injected), .result_data(result_data), .irq(irq));
  always #5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////
  // Converter core stand-in, result counter and run limit
  always @(posedge hclk) begin
    sh <= {sh[0], conv_start};
    conv_done <= sh[1];
    if (result_valid) begin
      nres++;
      last = result_data;
    end
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task close_out;
    $display("Errors %0d, checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(r, e);
  endtask
  // Trigger one group, let the sequence settle, count results
  task go(input logic inj, input int n);
    nres = 0;
    @(posedge hclk);
    if (inj) injected_trigger <= 1'h1;
    else regular_trigger <= 1'h1;
    @(posedge hclk);
    injected_trigger <= 1'h0;
    regular_trigger <= 1'h0;
    repeat (40) @(posedge hclk);
    chk(nres, n);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    bus(1'h1, 32'h4, 32'hFFFFFFFF);
    rd(32'h4, 32'h0000FFFF);
    bus(1'h1, 32'h0, 32'h1F);
    rd(32'h0, 32'h0);
    bus(1'h1, 32'h4, 32'h20);
    go(1'h0, 1);
    rd(32'h0, 32'h12);
    chk(irq, 1'h1);
    chk(last, 12'h5A5);
    bus(1'h1, 32'h0, 32'h1D);
    rd(32'h0, 32'h10);
    chk(irq, 1'h0);
    conv_channel <= 5'h0E;
    go(1'h0, 1);
    chk(last, 12'h000);
    conv_channel <= 5'h03;
    bus(1'h1, 32'h0, 32'h0);
    regular_last_pos <= 4'h2;
    bus(1'h1, 32'h4, 32'h120);
    go(1'h0, 3);
    rd(32'h0, 32'h12);
    bus(1'h1, 32'h0, 32'h0);
    regular_last_pos <= 4'h0;
    injected_last_pos <= 2'h1;
    bus(1'h1, 32'h4, 32'h580);
    go(1'h0, 3);
    rd(32'h0, 32'h1E);
    chk(irq, 1'h1);
    bus(1'h1, 32'h0, 32'h1B);
    rd(32'h0, 32'h1A);
    bus(1'h1, 32'h0, 32'h0);
    bus(1'h1, 32'h4, 32'h1100);
    go(1'h1, 1);
    rd(32'h0, 32'h08);
    go(1'h1, 1);
    rd(32'h0, 32'h0C);
    bus(1'h1, 32'h0, 32'h0);
    regular_last_pos <= 4'h3;
    bus(1'h1, 32'h4, 32'h2900);
    go(1'h0, 2);
    rd(32'h0, 32'h10);
    go(1'h0, 2);
    rd(32'h0, 32'h12);
    bus(1'h1, 32'h0, 32'h0);
    watchdog_enable <= 1'h1;
    watchdog_high <= 12'h800;
    watchdog_low <= 12'h100;
    conv_data <= 12'h900;
    regular_last_pos <= 4'h2;
    bus(1'h1, 32'h4, 32'h140);
    go(1'h0, 1);
    rd(32'h0, 32'h11);
    chk(irq, 1'h1);
    bus(1'h1, 32'h0, 32'h0);
    bus(1'h1, 32'h4, 32'h305);
    go(1'h0, 3);
    rd(32'h0, 32'h12);
    close_out();
  end
endmodule

bind adsc_scan_ctrl adsc_chk #(.INSTANCE_THREE(INSTANCE_THREE)) chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .regular_trigger(regular_trigger), .injected_trigger(injected_trigger),
  .conv_start(conv_start), .conv_injected(conv_injected), .conv_done(conv_done), .conv_channel(conv_channel),
  .conv_data(conv_data), .result_valid(result_valid), .result_injected(result_injected),
  .result_data(result_data), .irq(irq));
